// ---- logic/uart_ctrl_pkg.sv ----
// Shared constants for the UART interrupt, FIFO setup and line format block
package uart_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h00;
  localparam logic [7:0] OFS_FIFO_SETUP  = 8'h04;
  localparam logic [7:0] OFS_LINE_FORMAT = 8'h08;
  localparam logic [7:0] OFS_ENH_FEATURE = 8'h0c;
  localparam logic [7:0] OFS_FIFO_LEVELS = 8'h10;
  // FIFO geometry
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CNT_W      = 5;
  // Field positions
  localparam int unsigned FSC_ENABLE   = 0;
  localparam int unsigned FSC_RX_RESET = 1;
  localparam int unsigned FSC_TX_RESET = 2;
  localparam int unsigned FSC_DMA      = 3;
  localparam int unsigned FSC_TX_TRIG  = 4;
  localparam int unsigned FSC_RX_TRIG  = 6;
  localparam int unsigned EFC_ENHANCED = 4;
  localparam int unsigned LFC_STOP     = 2;
  localparam int unsigned LFC_PARITY   = 3;
  localparam int unsigned LFC_PTYPE    = 4;
  localparam int unsigned LFC_BREAK    = 6;
  localparam int unsigned LFC_DIVISOR  = 7;
  // Reset values
  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [7:0] EFC_RESET = 8'h00;
  localparam logic [1:0] TRIG_SEL_RESET = 2'h0;
  localparam logic [1:0] WLEN_5 = 2'h0;
  // Interrupt source indices, highest priority first
  localparam int unsigned NUM_SRC      = 7;
  localparam int unsigned SRC_LINE     = 0;
  localparam int unsigned SRC_TIMEOUT  = 1;
  localparam int unsigned SRC_RX_DATA  = 2;
  localparam int unsigned SRC_TX_READY = 3;
  localparam int unsigned SRC_MODEM    = 4;
  localparam int unsigned SRC_FLOW_CHR = 5;
  localparam int unsigned SRC_FLOW_PIN = 6;
  // Status codes in bits 5:0
  localparam logic [5:0] CODE_LINE     = 6'h06;
  localparam logic [5:0] CODE_TIMEOUT  = 6'h0c;
  localparam logic [5:0] CODE_RX_DATA  = 6'h04;
  localparam logic [5:0] CODE_TX_READY = 6'h02;
  localparam logic [5:0] CODE_MODEM    = 6'h00;
  localparam logic [5:0] CODE_FLOW_CHR = 6'h10;
  localparam logic [5:0] CODE_FLOW_PIN = 6'h20;
  localparam logic [5:0] CODE_NONE     = 6'h01;

  // Trigger select code to character count
  function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = 5'h01;
      2'h1: trig_level = 5'h04;
      2'h2: trig_level = 5'h08;
      default: trig_level = 5'h0e;
    endcase
  endfunction

  // Source index to status code
  function automatic logic [5:0] src_code(input logic [2:0] idx);
    case (idx)
      3'h0: src_code = CODE_LINE;
      3'h1: src_code = CODE_TIMEOUT;
      3'h2: src_code = CODE_RX_DATA;
      3'h3: src_code = CODE_TX_READY;
      3'h4: src_code = CODE_MODEM;
      3'h5: src_code = CODE_FLOW_CHR;
      default: src_code = CODE_FLOW_PIN;
    endcase
  endfunction
endpackage

// ---- logic/fifo_level_counter.sv ----
// Occupancy counter standing in for one character FIFO's pointers
`timescale 1ns/100ps
`default_nettype none
module fifo_level_counter
  import uart_ctrl_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned CW    = CNT_W
)(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic          pop,
  output logic [CW-1:0]      count_reg
);
  // Pushes into a full FIFO and pops from an empty one are dropped
  wire logic do_push = push && (count_reg != DEPTH[CW-1:0]);
  wire logic do_pop  = pop && (count_reg != '0);

  // Flush only touches the pointers, not any shift register outside
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= '0;
    else if (flush)
      count_reg <= '0;
    else if (do_push && !do_pop)
      count_reg <= count_reg + 1'b1;
    else if (do_pop && !do_push)
      count_reg <= count_reg - 1'b1;
  end
endmodule // fifo_level_counter
`default_nettype wire

// ---- logic/irq_priority_encoder.sv ----
// Picks the highest-priority pending source and gives its status code
`timescale 1ns/100ps
`default_nettype none
module irq_priority_encoder
  import uart_ctrl_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] pending,
  output logic [5:0]              code
);
  // Walk from lowest to highest so the highest pending one wins
  always_comb
  begin
    code = CODE_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (pending[i])
        code = src_code(i[2:0]);
    end
  end
endmodule // irq_priority_encoder
`default_nettype wire

// ---- logic/uart_irq_fifo_line_ctrl.sv ----
// UART channel interrupt status, FIFO setup and line format control on APB
// Summary of operation
// - Top three sources coded 06, 0C, 04
// - Lower four sources coded 02, 00, 10, 20
// - Bit 0 high when nothing pending
// - Flow-off/special char flag, cleared by read
// - Flow pin deassert flag needs enhanced mode
// - Bits 7:6 mirror FIFO enable
// - Other FIFO setup bits ignored unless bit 0 set
// - Bit 1 resets receive FIFO, self-clears
// - Bit 2 resets transmit FIFO, self-clears
// - Bit 3 selects DMA ready pin behaviour
// - Transmit trigger writable only when enhanced
// - Transmit interrupt on drop below trigger
// - Receive interrupt when level reaches trigger
// - FIFO setup register reads as zero
// - Word length five to eight bits
// - Stop bits one, one-half or two
// - Parity enable adds and checks parity
// - Parity type odd, even, mark, space
// - Read shows only highest; others wait
// - Transmit interrupt cleared by read or write
//
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module uart_irq_fifo_line_ctrl
  import uart_ctrl_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_char_push,
  input  wire logic        rx_char_pop,
  input  wire logic        tx_char_push,
  input  wire logic        tx_char_pop,
  input  wire logic        line_error_pending,
  input  wire logic        rx_timeout_pending,
  input  wire logic        modem_change_pending,
  input  wire logic        flow_off_match,
  input  wire logic        special_char_match,
  input  wire logic        flow_pin_deassert,
  output logic             rx_fifo_clear,
  output logic             tx_fifo_clear,
  output logic             fifo_enable,
  output logic [1:0]       word_len_sel,
  output logic [1:0]       stop_mode,
  output logic             parity_enable,
  output logic [1:0]       parity_type,
  output logic             break_enable,
  output logic             divisor_select,
  output logic             irq_active,
  output logic             tx_ready_pin_n,
  output logic             rx_ready_pin_n
);
  // Register state
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic             fifo_en_reg;
  logic             dma_reg;
  logic [1:0]       tx_trig_sel_reg;
  logic [1:0]       rx_trig_sel_reg;
  logic             rx_flush_reg;
  logic             tx_flush_reg;
  logic [7:0]       lfc_reg;
  logic [1:0]       stop_mode_reg;
  logic [7:0]       efc_reg;
  logic             tx_irq_reg;
  logic             tx_above_reg;
  logic             flow_chr_reg;
  logic             special_reg;
  logic             irq_active_reg;
  logic             tx_pin_n_reg;
  logic             rx_pin_n_reg;
  logic [CNT_W-1:0] rx_count;
  logic [CNT_W-1:0] tx_count;
  logic [5:0]       irq_code;

  // Address decode, used for both write strobes and error answer
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_IRQ_STATUS) || (a == OFS_FIFO_SETUP) || (a == OFS_LINE_FORMAT)
                || (a == OFS_ENH_FEATURE) || (a == OFS_FIFO_LEVELS);
  endfunction

  // Bus phases: answer in the first access cycle, no wait states
  wire logic setup_ph  = psel && !penable;
  wire logic access_ok = psel && penable && pready_reg;
  wire logic wr_ok     = access_ok && pwrite && is_mapped(paddr);
  wire logic fsc_wr    = wr_ok && (paddr == OFS_FIFO_SETUP);
  wire logic lfc_wr    = wr_ok && (paddr == OFS_LINE_FORMAT);
  wire logic efc_wr    = wr_ok && (paddr == OFS_ENH_FEATURE);
  wire logic isr_rd    = access_ok && !pwrite && (paddr == OFS_IRQ_STATUS);
  wire logic enhanced  = efc_reg[EFC_ENHANCED];

  // Effective trigger levels; without FIFOs the holding register acts as depth one
  wire logic [CNT_W-1:0] tx_trig = fifo_en_reg ? trig_level(tx_trig_sel_reg) : trig_level(TRIG_SEL_RESET);
  wire logic [CNT_W-1:0] rx_trig = fifo_en_reg ? trig_level(rx_trig_sel_reg) : trig_level(TRIG_SEL_RESET);

  // Status word: FIFO enable mirror over the encoded source
  wire logic [7:0] isr_value = {{2{fifo_en_reg}}, irq_code};

  // Read data mux; the FIFO setup register gives no readback
  wire logic [31:0] rd_data =
    (paddr == OFS_IRQ_STATUS)  ? {24'h000000, isr_value} :
    (paddr == OFS_LINE_FORMAT) ? {24'h000000, lfc_reg} :
    (paddr == OFS_ENH_FEATURE) ? {24'h000000, efc_reg} :
    (paddr == OFS_FIFO_LEVELS) ? {16'h0000, 3'h0, tx_count, 3'h0, rx_count} :
    32'h00000000;

  // FIFO occupancy, sixteen deep by default
  fifo_level_counter #(.DEPTH(DEPTH), .CW(CNT_W)) u_rx_level (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (rx_flush_reg),
    .push      (rx_char_push),
    .pop       (rx_char_pop),
    .count_reg (rx_count)
  );
  fifo_level_counter #(.DEPTH(DEPTH), .CW(CNT_W)) u_tx_level (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (tx_flush_reg),
    .push      (tx_char_push),
    .pop       (tx_char_pop),
    .count_reg (tx_count)
  );

  // Transmit interrupt: fall below trigger, or empty after a short reload
  wire logic tx_drop = tx_char_pop && (tx_count != '0)
                       && ((tx_count == tx_trig) || ((tx_count == 5'h01) && !tx_above_reg));
  wire logic tx_set  = tx_drop || tx_flush_reg;
  wire logic tx_clr  = (isr_rd && (prdata_reg[5:0] == CODE_TX_READY)) || tx_char_push;
  wire logic tx_irq_next = tx_set || (tx_irq_reg && !tx_clr);

  // Flow-off and special character flags; a new match beats a clear
  wire logic chr_clr      = isr_rd && (prdata_reg[5:0] == CODE_FLOW_CHR);
  wire logic flow_chr_next = (flow_off_match && enhanced) || (flow_chr_reg && !chr_clr);
  wire logic special_next  = (special_char_match && enhanced)
                             || (special_reg && !chr_clr && !rx_char_push);

  // Pending sources, index order is priority order
  wire logic [NUM_SRC-1:0] src_pending = {
    flow_pin_deassert && enhanced,
    flow_chr_reg || special_reg,
    modem_change_pending,
    tx_irq_reg,
    (rx_count != '0) && (rx_count >= rx_trig),
    rx_timeout_pending,
    line_error_pending
  };

  // Only the top pending source shows; lower ones stay set until serviced
  irq_priority_encoder u_prio (
    .pending (src_pending),
    .code    (irq_code)
  );

  // Ready pins: normal mode per character, DMA mode per trigger or space
  wire logic dma_on       = dma_reg && fifo_en_reg;
  wire logic rx_pin_n_next = dma_on ? !((rx_count >= rx_trig) || rx_timeout_pending)
                                    : (rx_count == '0);
  wire logic tx_pin_n_next = dma_on ? (tx_count == DEPTH[CNT_W-1:0]) : (tx_count != '0);

  // Stop length depends on word length as well
  wire logic [1:0] stop_next = !pwdata[LFC_STOP] ? 2'h0 :
                               (pwdata[1:0] == WLEN_5) ? 2'h1 : 2'h2;

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
    else
    begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph && !is_mapped(paddr);
      if (setup_ph)
        prdata_reg <= pwrite ? 32'h00000000 : rd_data;
    end
  end

  // FIFO setup: fields taken only when the enable bit is written as one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fifo_en_reg     <= 1'b0;
      dma_reg         <= 1'b0;
      tx_trig_sel_reg <= TRIG_SEL_RESET;
      rx_trig_sel_reg <= TRIG_SEL_RESET;
      rx_flush_reg    <= 1'b0;
      tx_flush_reg    <= 1'b0;
    end
    else
    begin
      // Resets are one-cycle pulses; turning enable from on to off also empties both FIFOs
      rx_flush_reg <= fsc_wr && (pwdata[FSC_RX_RESET] || !pwdata[FSC_ENABLE])
                      && (pwdata[FSC_ENABLE] || fifo_en_reg);
      tx_flush_reg <= fsc_wr && (pwdata[FSC_TX_RESET] || !pwdata[FSC_ENABLE])
                      && (pwdata[FSC_ENABLE] || fifo_en_reg);
      if (fsc_wr)
      begin
        fifo_en_reg <= pwdata[FSC_ENABLE];
        if (pwdata[FSC_ENABLE])
        begin
          dma_reg         <= pwdata[FSC_DMA];
          rx_trig_sel_reg <= pwdata[FSC_RX_TRIG +: 2];
          if (enhanced)
            tx_trig_sel_reg <= pwdata[FSC_TX_TRIG +: 2];
        end
      end
    end
  end

  // Line format and enhanced feature registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lfc_reg       <= LFC_RESET;
      stop_mode_reg <= 2'h0;
      efc_reg       <= EFC_RESET;
    end
    else
    begin
      if (lfc_wr)
      begin
        lfc_reg       <= pwdata[7:0];
        stop_mode_reg <= stop_next;
      end
      if (efc_wr)
        efc_reg <= pwdata[7:0];
    end
  end

  // Interrupt flags and pin drivers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_irq_reg     <= 1'b0;
      tx_above_reg   <= 1'b0;
      flow_chr_reg   <= 1'b0;
      special_reg    <= 1'b0;
      irq_active_reg <= 1'b0;
      tx_pin_n_reg   <= 1'b0;
      rx_pin_n_reg   <= 1'b1;
    end
    else
    begin
      tx_irq_reg     <= tx_irq_next;
      flow_chr_reg   <= flow_chr_next;
      special_reg    <= special_next;
      irq_active_reg <= (src_pending != '0);
      tx_pin_n_reg   <= tx_pin_n_next;
      rx_pin_n_reg   <= rx_pin_n_next;
      // Remembers whether the last reload went past the trigger
      if (tx_count > tx_trig)
        tx_above_reg <= 1'b1;
      else if (tx_count == '0)
        tx_above_reg <= 1'b0;
    end
  end

  // Outputs straight from flip-flops
  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign rx_fifo_clear  = rx_flush_reg;
  assign tx_fifo_clear  = tx_flush_reg;
  assign fifo_enable    = fifo_en_reg;
  assign word_len_sel   = lfc_reg[1:0];
  assign stop_mode      = stop_mode_reg;
  assign parity_enable  = lfc_reg[LFC_PARITY];
  assign parity_type    = lfc_reg[LFC_PTYPE +: 2];
  assign break_enable   = lfc_reg[LFC_BREAK];
  assign divisor_select = lfc_reg[LFC_DIVISOR];
  assign irq_active     = irq_active_reg;
  assign tx_ready_pin_n = tx_pin_n_reg;
  assign rx_ready_pin_n = rx_pin_n_reg;

  // Checks on priority coding, FIFO setup and line format
  property p_line_top;
    @(posedge pclk) disable iff (!presetn) line_error_pending |-> isr_value[5:0] == CODE_LINE;
  endproperty
  a_line_top: assert property (p_line_top) else $error("line status not top priority");
  property p_timeout_second;
    @(posedge pclk) disable iff (!presetn)
      (!line_error_pending && rx_timeout_pending) |-> isr_value[5:0] == CODE_TIMEOUT;
  endproperty
  a_timeout_second: assert property (p_timeout_second) else $error("timeout code wrong");
  property p_pin_lowest;
    @(posedge pclk) disable iff (!presetn)
      (src_pending == 7'h40) |-> isr_value[5:0] == CODE_FLOW_PIN;
  endproperty
  a_pin_lowest: assert property (p_pin_lowest) else $error("flow pin code wrong");
  property p_none_bit;
    @(posedge pclk) disable iff (!presetn) (src_pending == '0) |-> isr_value[0] ##1 !irq_active;
  endproperty
  a_none_bit: assert property (p_none_bit) else $error("idle status bit wrong");
  property p_fifo_mirror;
    @(posedge pclk) disable iff (!presetn) isr_rd |-> prdata[7:6] == {2{fifo_en_reg}};
  endproperty
  a_fifo_mirror: assert property (p_fifo_mirror) else $error("enable mirror wrong");
  property p_ignore_disabled;
    @(posedge pclk) disable iff (!presetn)
      (fsc_wr && !pwdata[FSC_ENABLE]) |=> $stable(dma_reg) && $stable(rx_trig_sel_reg) && !fifo_en_reg;
  endproperty
  a_ignore_disabled: assert property (p_ignore_disabled) else $error("setup taken without enable");
  property p_rx_reset;
    @(posedge pclk) disable iff (!presetn)
      (fsc_wr && pwdata[FSC_ENABLE] && pwdata[FSC_RX_RESET]) |=> rx_fifo_clear ##1 !rx_fifo_clear;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receive reset not a pulse");
  property p_tx_trig_locked;
    @(posedge pclk) disable iff (!presetn) (fsc_wr && !enhanced) |=> $stable(tx_trig_sel_reg);
  endproperty
  a_tx_trig_locked: assert property (p_tx_trig_locked) else $error("trigger written without enhanced");
  property p_tx_drop;
    @(posedge pclk) disable iff (!presetn) tx_drop |=> tx_irq_reg;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("transmit interrupt missed");
  property p_tx_clear;
    @(posedge pclk) disable iff (!presetn) (tx_char_push && !tx_set) |=> !tx_irq_reg;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("transmit interrupt not cleared");
  property p_half_stop;
    @(posedge pclk) disable iff (!presetn)
      (lfc_wr && pwdata[LFC_STOP] && pwdata[1:0] == WLEN_5) |=> stop_mode == 2'h1 && word_len_sel == WLEN_5;
  endproperty
  a_half_stop: assert property (p_half_stop) else $error("stop length wrong");
  c_isr_read: cover property (@(posedge pclk) disable iff (!presetn) isr_rd && tx_irq_reg);
  c_fifo_on: cover property (@(posedge pclk) disable iff (!presetn) fsc_wr && pwdata[FSC_ENABLE]);
  c_rx_trig: cover property (@(posedge pclk) disable iff (!presetn) fifo_en_reg && src_pending[SRC_RX_DATA]);
endmodule // uart_irq_fifo_line_ctrl
`default_nettype wire

// ---- bench/datapath_model.sv ----
// Behavioural datapath that moves characters and raises match strobes
`timescale 1ns/100ps
`default_nettype none
module datapath_model
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      rx_char_push,
  output logic      rx_char_pop,
  output logic      tx_char_push,
  output logic      tx_char_pop,
  output logic      flow_off_match,
  output logic      special_char_match
);
  logic [5:0] strobe_reg = 6'h00;

  // Each char is its own one-cycle pulse, with a gap so counts move one at a time
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      strobe_reg[idx] <= 1'b1;
      @(posedge pclk);
      strobe_reg[idx] <= 1'b0;
    end
  endtask

  // Strobes are masked in reset so no char moves before the block is up
  assign rx_char_push       = strobe_reg[0] & presetn;
  assign rx_char_pop        = strobe_reg[1] & presetn;
  assign tx_char_push       = strobe_reg[2] & presetn;
  assign tx_char_pop        = strobe_reg[3] & presetn;
  assign flow_off_match     = strobe_reg[4] & presetn;
  assign special_char_match = strobe_reg[5] & presetn;
endmodule // datapath_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench for the UART interrupt, FIFO setup and line format block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import uart_ctrl_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        rxp, rxq, txp, txq, fom, scm;
  logic        line_err = 1'b0;
  logic        rx_to = 1'b0;
  logic        modem = 1'b0;
  logic        flow_pin = 1'b0;
  logic        rx_clr, tx_clr, fifo_en, par_en, brk, dsel, irq, txr_n, rxr_n;
  logic [1:0]  wlen, stop, ptype;
  logic [31:0] q;
  logic        e;
  int          fail_count = 0;
  int          num_checks = 0;
  logic [5:0]  codes [7] = '{CODE_LINE, CODE_TIMEOUT, CODE_RX_DATA, CODE_TX_READY,
                             CODE_MODEM, CODE_FLOW_CHR, CODE_FLOW_PIN};

  always #50 pclk = ~pclk;

  datapath_model i_datapath_model (.pclk(pclk), .presetn(presetn), .rx_char_push(rxp),
    .rx_char_pop(rxq), .tx_char_push(txp), .tx_char_pop(txq), .flow_off_match(fom),
    .special_char_match(scm));

  uart_irq_fifo_line_ctrl i_uart_irq_fifo_line_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_char_push(rxp),
    .rx_char_pop(rxq), .tx_char_push(txp), .tx_char_pop(txq),
    .line_error_pending(line_err), .rx_timeout_pending(rx_to), .modem_change_pending(modem),
    .flow_off_match(fom), .special_char_match(scm), .flow_pin_deassert(flow_pin),
    .rx_fifo_clear(rx_clr), .tx_fifo_clear(tx_clr), .fifo_enable(fifo_en),
    .word_len_sel(wlen), .stop_mode(stop), .parity_enable(par_en), .parity_type(ptype),
    .break_enable(brk), .divisor_select(dsel), .irq_active(irq),
    .tx_ready_pin_n(txr_n), .rx_ready_pin_n(rxr_n));

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    q = prdata;
    e = pslverr;
    if (n >= 20)
      check("pready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] mask);
    apb(1'b0, a, 32'h0);
    check(nm, exp, q & mask);
  endtask

  // Outputs are read at a rising edge, before that edge's updates land
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  initial
  begin
    #(100 * 20000);
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped place
    rd("status", OFS_IRQ_STATUS, 32'h01, '1);
    rd("fifo_setup", OFS_FIFO_SETUP, 32'h0, '1);
    rd("line_format", OFS_LINE_FORMAT, 32'(LFC_RESET), '1);
    check("word_len_sel", 32'(WLEN_5), 32'(wlen));
    rd("unmapped", 8'h14, 32'h0, '1);
    check("pslverr", 32'h1, 32'(e));
    $display("test reset done");
    // Every word length and parity type with the long stop setting
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, OFS_LINE_FORMAT, 32'({2'b00, i[1:0], 2'b11, i[1:0]}));
      rd("line_format", OFS_LINE_FORMAT, 32'({2'b00, i[1:0], 2'b11, i[1:0]}), '1);
      check("word_len_sel", 32'(i[1:0]), 32'(wlen));
      check("stop_mode", (i == 0) ? 32'h1 : 32'h2, 32'(stop));
      check("parity_enable", 32'h1, 32'(par_en));
      check("parity_type", 32'(i[1:0]), 32'(ptype));
    end
    apb(1'b1, OFS_LINE_FORMAT, 32'hc3);
    idle(1);
    check("stop_mode", 32'h0, 32'(stop));
    check("parity_enable", 32'h0, 32'(par_en));
    check("break_divisor", 32'h3, 32'({brk, dsel}));
    $display("test line format done");
    // All seven sources pending, serviced from the top down
    apb(1'b1, OFS_ENH_FEATURE, 32'h10);
    @(posedge pclk);
    line_err <= 1'b1;
    rx_to <= 1'b1;
    modem <= 1'b1;
    flow_pin <= 1'b1;
    i_datapath_model.pulse(0, 1);
    i_datapath_model.pulse(2, 1);
    i_datapath_model.pulse(3, 1);
    i_datapath_model.pulse(4, 1);
    for (int k = 0; k < 7; k++)
    begin
      idle(3);
      rd("status", OFS_IRQ_STATUS, 32'(codes[k]), '1);
      check("irq_active", 32'h1, 32'(irq));
      @(posedge pclk);
      case (k)
        0: line_err <= 1'b0;
        1: rx_to <= 1'b0;
        2: i_datapath_model.pulse(1, 1);
        4: modem <= 1'b0;
        6: flow_pin <= 1'b0;
        default: ;
      endcase
    end
    idle(3);
    rd("status", OFS_IRQ_STATUS, 32'h01, '1);
    check("irq_active", 32'h0, 32'(irq));
    check("ready_pins", 32'h2, 32'({rxr_n, txr_n}));
    $display("test priority done");
    // Receive trigger, ready pin modes and receive reset
    apb(1'b1, OFS_FIFO_SETUP, 32'h41);
    idle(1);
    check("fifo_enable", 32'h1, 32'(fifo_en));
    rd("fifo_setup", OFS_FIFO_SETUP, 32'h0, '1);
    i_datapath_model.pulse(0, 3);
    idle(3);
    rd("status", OFS_IRQ_STATUS, 32'hc1, '1);
    check("rx_ready_pin_n", 32'h0, 32'(rxr_n));
    apb(1'b1, OFS_FIFO_SETUP, 32'h49);
    idle(2);
    check("rx_ready_pin_n", 32'h1, 32'(rxr_n));
    i_datapath_model.pulse(0, 1);
    idle(3);
    rd("status", OFS_IRQ_STATUS, 32'hc4, '1);
    check("rx_ready_pin_n", 32'h0, 32'(rxr_n));
    apb(1'b1, OFS_FIFO_SETUP, 32'h43);
    idle(1);
    check("rx_fifo_clear", 32'h1, 32'(rx_clr));
    idle(1);
    check("rx_fifo_clear", 32'h0, 32'(rx_clr));
    idle(2);
    rd("levels", OFS_FIFO_LEVELS, 32'h0, '1);
    // Transmit reset, then transmit trigger of four
    i_datapath_model.pulse(2, 5);
    apb(1'b1, OFS_FIFO_SETUP, 32'h05);
    idle(1);
    check("tx_fifo_clear", 32'h1, 32'(tx_clr));
    idle(3);
    rd("levels", OFS_FIFO_LEVELS, 32'h0, '1);
    rd("status", OFS_IRQ_STATUS, 32'hc2, '1);
    apb(1'b1, OFS_FIFO_SETUP, 32'h11);
    i_datapath_model.pulse(2, 5);
    i_datapath_model.pulse(3, 2);
    idle(3);
    rd("levels", OFS_FIFO_LEVELS, 32'h0300, '1);
    rd("status", OFS_IRQ_STATUS, 32'hc2, '1);
    rd("status", OFS_IRQ_STATUS, 32'hc1, '1);
    i_datapath_model.pulse(3, 3);
    idle(3);
    rd("status", OFS_IRQ_STATUS, 32'hc1, '1);
    // With enhanced off the transmit trigger field must stay at four
    apb(1'b1, OFS_ENH_FEATURE, 32'h00);
    apb(1'b1, OFS_FIFO_SETUP, 32'h01);
    i_datapath_model.pulse(2, 5);
    i_datapath_model.pulse(3, 2);
    idle(3);
    rd("status", OFS_IRQ_STATUS, 32'hc2, '1);
    // That read cleared the flag; raise it again so only the write can clear it
    i_datapath_model.pulse(2, 1);
    i_datapath_model.pulse(3, 1);
    idle(3);
    check("irq_active", 32'h1, 32'(irq));
    i_datapath_model.pulse(2, 1);
    idle(3);
    rd("status", OFS_IRQ_STATUS, 32'hc1, '1);
    // Empty after a reload that never passed the trigger
    i_datapath_model.pulse(3, 4);
    i_datapath_model.pulse(2, 2);
    i_datapath_model.pulse(3, 2);
    idle(3);
    rd("status", OFS_IRQ_STATUS, 32'hc2, '1);
    // A write without bit 0 turns the FIFOs off and empties both; other fields keep their values
    apb(1'b1, OFS_FIFO_SETUP, 32'h0e);
    idle(2);
    check("fifo_enable", 32'h0, 32'(fifo_en));
    rd("status", OFS_IRQ_STATUS, 32'h00, 32'hc0);
    $display("test fifo setup done");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
